// ---- verilog/mas_pkg.sv ----
// Shared constants for the multiplexed channel scanner
package mas_pkg;
	// Channel and sample widths
	localparam int CHAN_W = 3;
	localparam int CODE_W = 12;
	localparam int ENTRY_W = CHAN_W + CODE_W;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 8;

	// Jumper weights, fixed by the channel-count straps
	localparam logic [CHAN_W-1:0] JMP_W1 = 3'h1;
	localparam logic [CHAN_W-1:0] JMP_W2 = 3'h2;
	localparam logic [CHAN_W-1:0] JMP_W4 = 3'h4;
	localparam int JMP_BIT1 = 0;
	localparam int JMP_BIT2 = 1;
	localparam int JMP_BIT4 = 2;

	// Entry layout in the FIFO: index above the code
	localparam int ENT_CODE_LSB = 0;
	localparam int ENT_IDX_LSB = CODE_W;

	// Upper input byte layout
	localparam int UP_TOP_BIT = 7;
	localparam int UP_IDX_LSB = 4;
	localparam int UP_CODE_W = 4;
	localparam int LOW_CODE_W = 8;

	// Reset values of the two input bytes and the channel pointer
	localparam logic [BYTE_W-1:0] LOW_RST = 8'h00;
	localparam logic [BYTE_W-1:0] UP_RST = 8'h00;
	localparam logic [CHAN_W-1:0] CHAN_FIRST = 3'h0;
	localparam logic [CODE_W-1:0] CODE_RST = 12'h000;

	// Conversion time per channel and its cycle count at 20 MHz
	localparam int CONV_TIME_NS = 35000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CNT_W = $clog2(CONV_CYCLES + 1);
endpackage

// ---- verilog/mas_fifo_if.sv ----
// Valid/ready carrier between the scanner and its FIFO
`timescale 1ns/10ps
`default_nettype none
interface mas_fifo_if #(
	parameter int WIDTH = 15
);
	logic wr_valid;
	logic wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [WIDTH-1:0] rd_data;

	// FIFO side takes writes and offers reads
	modport fifo (
		input wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data
	);

	// User side pushes conversions and pops presentations
	modport user (
		output wr_valid, wr_data, rd_ready,
		input wr_ready, rd_valid, rd_data
	);
endinterface
`default_nettype wire

// ---- verilog/mas_fifo.sv ----
// Synchronous FIFO holding indexed conversion results
`timescale 1ns/10ps
`default_nettype none
module mas_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 8
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	mas_fifo_if.fifo port_io
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0] count_q;
	logic do_wr;
	logic do_rd;

	// Honest flags straight from the fill count
	assign port_io.wr_ready = (count_q != DEPTH[AW:0]);
	assign port_io.rd_valid = (count_q != '0);
	assign port_io.rd_data = mem_q[rptr_q];
	assign do_wr = port_io.wr_valid && port_io.wr_ready;
	assign do_rd = port_io.rd_ready && port_io.rd_valid;

	// Storage array, no reset needed on data
	always_ff @(posedge clock_i) begin
		if (do_wr) begin
			mem_q[wptr_q] <= port_io.wr_data;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			if (do_wr) begin
				wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
			end
			if (do_rd) begin
				rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
			end
		end
	end

	// Fill count
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			count_q <= '0;
		end else if (do_wr && !do_rd) begin
			count_q <= count_q + 1'b1;
		end else if (do_rd && !do_wr) begin
			count_q <= count_q - 1'b1;
		end
	end
endmodule // mas_fifo
`default_nettype wire

// ---- verilog/mas_scanner.sv ----
// Channel scanner: converter sequencing and per-scan input presentation
//
// Overview of operation
// - Enabled count is one plus jumper weights
// - Channels above count never converted nor shown
// - All three jumpers give eight channels
// - One channel presented per host scan
// - After last enabled channel, return to 1
// - All enabled channels refreshed within N scans
// - Conversion free-running; outputs change only on scans (code halts conversion while the FIFO is full)
// - Sixteen input points as two bytes
// - Three bits below top carry channel index
// - Index is channel minus one, increments
// - Twelve bits unsigned binary, bit0 LSB
// - Code 0 bottom, 4095 top of range
//
// Data path
// Straps set the last enabled index
// Sequencer starts the converter, one channel at a time
// Done edge captures the code into one FIFO word
// Host scan edge pops one word into the two input bytes
// Limitations
// Straps are read live; change them only under reset
// Shown data may trail the converter by eight words
// Empty FIFO at a scan keeps both bytes as they were
`timescale 1ns/10ps
`default_nettype none
module mas_scanner #(
	parameter int FIFO_DEPTH = mas_pkg::FIFO_DEPTH
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [mas_pkg::CHAN_W-1:0] chan_jumper_i,
	input wire logic host_scan_i,
	input wire logic conv_done_i,
	input wire logic [mas_pkg::CODE_W-1:0] conv_code_i,
	output logic conv_start_o,
	output logic [mas_pkg::CHAN_W-1:0] conv_chan_o,
	output logic [mas_pkg::BYTE_W-1:0] sample_low_byte_o,
	output logic [mas_pkg::BYTE_W-1:0] channel_index_and_sample_high_o
);
	import mas_pkg::*;

	// Converter sequencer states
	typedef enum logic [3:0] {
		CV_IDLE = 4'h1,
		CV_START = 4'h2,
		CV_WAIT = 4'h4,
		CV_PUSH = 4'h8
	} mas_conv_state_t;

	mas_conv_state_t cv_state_q;
	mas_conv_state_t cv_state_d;

	// Strap synchroniser
	logic [CHAN_W-1:0] jmp_meta_q;
	logic [CHAN_W-1:0] jmp_sync_q;

	// Scan strobe synchroniser and edge history
	logic scan_meta_q;
	logic scan_sync_q;
	logic scan_prev_q;

	// Done synchroniser and edge history
	logic done_meta_q;
	logic done_sync_q;
	logic done_prev_q;

	// Code bus synchroniser
	logic [CODE_W-1:0] code_meta_q;
	logic [CODE_W-1:0] code_sync_q;

	// Strap decode and converter pointer
	logic [CHAN_W-1:0] last_chan;
	logic [CHAN_W-1:0] conv_ptr_q;
	logic [CHAN_W-1:0] conv_ptr_next;
	logic ptr_in_range;
	logic [CHAN_W-1:0] start_chan;

	// Conversion timing, result and FIFO push
	logic [CODE_W-1:0] result_q;
	logic [CONV_CNT_W-1:0] conv_cnt_q;
	logic conv_min_met;
	logic done_seen_q;
	logic push_fire;

	// Detected edges of the synchronised strobes
	logic scan_edge;
	logic done_edge;

	// FIFO head fields and scan decision
	logic [CHAN_W-1:0] head_chan;
	logic [CODE_W-1:0] head_code;
	logic head_stale;
	logic present;

	// Input byte registers
	logic [BYTE_W-1:0] low_q;
	logic up_top_q;
	logic [CHAN_W-1:0] up_idx_q;
	logic [UP_CODE_W-1:0] up_code_q;

	mas_fifo_if #(.WIDTH(ENTRY_W)) fifo_bus ();

	// Two-flop synchronisers; only the second stage feeds any logic
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			jmp_meta_q <= '0;
			jmp_sync_q <= '0;
		end else begin
			jmp_meta_q <= chan_jumper_i;
			jmp_sync_q <= jmp_meta_q;
		end
	end

	// Host scan strobe synchroniser
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			scan_meta_q <= 1'b0;
			scan_sync_q <= 1'b0;
		end else begin
			scan_meta_q <= host_scan_i;
			scan_sync_q <= scan_meta_q;
		end
	end

	// Scan edge history; reset low so no false edge follows reset
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			scan_prev_q <= 1'b0;
		end else begin
			scan_prev_q <= scan_sync_q;
		end
	end

	// Converter done synchroniser
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			done_meta_q <= 1'b0;
			done_sync_q <= 1'b0;
		end else begin
			done_meta_q <= conv_done_i;
			done_sync_q <= done_meta_q;
		end
	end

	// Done edge history, reset to the idle level of the pin
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			done_prev_q <= 1'b0;
		end else begin
			done_prev_q <= done_sync_q;
		end
	end

	// Code bus synchroniser; the code is settled once done is seen
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			code_meta_q <= CODE_RST;
			code_sync_q <= CODE_RST;
		end else begin
			code_meta_q <= conv_code_i;
			code_sync_q <= code_meta_q;
		end
	end

	// Rising edges of the synchronised strobes
	assign scan_edge = scan_sync_q && !scan_prev_q;
	assign done_edge = done_sync_q && !done_prev_q;

	// Last enabled index: the straps add 1, 2 and 4 to channel 1
	always_comb begin
		last_chan = CHAN_FIRST;
		if (jmp_sync_q[JMP_BIT1]) begin
			last_chan = last_chan + JMP_W1;
		end
		if (jmp_sync_q[JMP_BIT2]) begin
			last_chan = last_chan + JMP_W2;
		end
		if (jmp_sync_q[JMP_BIT4]) begin
			last_chan = last_chan + JMP_W4;
		end
	end

	// Next channel to convert; a pointer beyond the count also wraps
	assign conv_ptr_next = (conv_ptr_q >= last_chan) ? CHAN_FIRST : conv_ptr_q + 1'b1;

	// Pointer still inside the enabled range
	assign ptr_in_range = (conv_ptr_q <= last_chan);

	// Channel of the next start; a pointer beyond the count restarts at 1
	always_comb begin
		start_chan = conv_ptr_q;
		if (!ptr_in_range) begin
			start_chan = CHAN_FIRST;
		end
	end

	// Conversion runs on its own, paced only by the converter done, the minimum conversion time and FIFO room
	always_comb begin
		cv_state_d = cv_state_q;
		case (cv_state_q)
			CV_IDLE: begin
				if (fifo_bus.wr_ready) begin
					cv_state_d = CV_START;
				end
			end
			CV_START: begin
				cv_state_d = CV_WAIT;
			end
			CV_WAIT: begin
				if (done_seen_q && conv_min_met) begin
					cv_state_d = CV_PUSH;
				end
			end
			CV_PUSH: begin
				// Back through idle so a start waits for the updated FIFO room
				cv_state_d = CV_IDLE;
			end
			default: begin
				cv_state_d = CV_IDLE;
			end
		endcase
	end

	// Sequencer state register
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			cv_state_q <= CV_IDLE;
		end else begin
			cv_state_q <= cv_state_d;
		end
	end

	// Converted channel pointer advances once per stored result
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			conv_ptr_q <= CHAN_FIRST;
		end else if (push_fire) begin
			conv_ptr_q <= conv_ptr_next;
		end else if (cv_state_q == CV_IDLE && !ptr_in_range) begin
			conv_ptr_q <= CHAN_FIRST;
		end
	end

	// Minimum conversion time guards against a done left over from before
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			conv_cnt_q <= '0;
		end else if (cv_state_q == CV_START) begin
			conv_cnt_q <= '0;
		end else if (cv_state_q == CV_WAIT && !conv_min_met) begin
			conv_cnt_q <= conv_cnt_q + 1'b1;
		end
	end

	assign conv_min_met = (conv_cnt_q >= CONV_CNT_W'(CONV_CYCLES - 1));

	// Done is remembered so an early completion is not lost
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			done_seen_q <= 1'b0;
		end else if (cv_state_q == CV_START) begin
			done_seen_q <= 1'b0;
		end else if (cv_state_q == CV_WAIT && done_edge) begin
			done_seen_q <= 1'b1;
		end
	end

	// Result capture on the done edge, unsigned straight binary
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			result_q <= CODE_RST;
		end else if (cv_state_q == CV_WAIT && done_edge) begin
			result_q <= code_sync_q;
		end
	end

	// One-cycle start pulse on entry to the start state
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			conv_start_o <= 1'b0;
		end else begin
			conv_start_o <= (cv_state_d == CV_START) && (cv_state_q != CV_START);
		end
	end

	// Channel select; held steady through the whole conversion
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			conv_chan_o <= CHAN_FIRST;
		end else if ((cv_state_d == CV_START) && (cv_state_q == CV_IDLE)) begin
			conv_chan_o <= start_chan;
		end
	end

	// Index and code travel as one word, so they cannot be split
	assign fifo_bus.wr_valid = (cv_state_q == CV_PUSH);
	assign fifo_bus.wr_data = {conv_ptr_q, result_q};
	assign push_fire = fifo_bus.wr_valid && fifo_bus.wr_ready;

	mas_fifo #(
		.WIDTH(ENTRY_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.port_io(fifo_bus)
	);

	// Head entry fields
	assign head_chan = fifo_bus.rd_data[ENT_IDX_LSB +: CHAN_W];
	assign head_code = fifo_bus.rd_data[ENT_CODE_LSB +: CODE_W];

	// Entries beyond a reduced count are dropped without being shown
	assign head_stale = fifo_bus.rd_valid && (head_chan > last_chan);
	assign present = scan_edge && fifo_bus.rd_valid && !head_stale;
	assign fifo_bus.rd_ready = head_stale || present;

	// One entry per scan; held over a scan that finds the FIFO empty
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			low_q <= LOW_RST;
		end else if (present) begin
			low_q <= head_code[LOW_CODE_W-1:0];
		end
	end

	// Upper byte top bit carries nothing and stays zero
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			up_top_q <= UP_RST[UP_TOP_BIT];
		end else if (present) begin
			up_top_q <= 1'b0;
		end
	end

	// Channel index, loaded with its code from the same FIFO word
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			up_idx_q <= UP_RST[UP_IDX_LSB +: CHAN_W];
		end else if (present) begin
			up_idx_q <= head_chan;
		end
	end

	// Top four code bits of the presented sample
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			up_code_q <= UP_RST[UP_CODE_W-1:0];
		end else if (present) begin
			up_code_q <= head_code[CODE_W-1 -: UP_CODE_W];
		end
	end

	// Sixteen input points, entries stored in channel order wrap to index 0
	assign sample_low_byte_o = low_q;
	assign channel_index_and_sample_high_o = {up_top_q, up_idx_q, up_code_q};
endmodule // mas_scanner
`default_nettype wire

// ---- tb/mas_scanner_chk.sv ----
// Port-level assertions for the channel scanner
`timescale 1ns/10ps
`default_nettype none
module mas_scanner_chk
	import mas_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [CHAN_W-1:0] chan_jumper_i,
	input wire logic host_scan_i,
	input wire logic conv_done_i,
	input wire logic [CODE_W-1:0] conv_code_i,
	input wire logic conv_start_o,
	input wire logic [CHAN_W-1:0] conv_chan_o,
	input wire logic [BYTE_W-1:0] sample_low_byte_o,
	input wire logic [BYTE_W-1:0] channel_index_and_sample_high_o
);
	logic [3:0] age_q;
	logic [9:0] gap_q;
	logic [2:0] last_q;
	wire logic [2:0] idx = channel_index_and_sample_high_o[6:4];
	// Cycles since the scan pin rose; saturates so long idle spells stay quiet
	always_ff @(posedge clock_i) begin
		if (!nrst_i) age_q <= 4'hF;
		else if ($rose(host_scan_i)) age_q <= 4'h0;
		else if (age_q != 4'hF) age_q <= age_q + 4'h1;
	end
	// Cycles since the last start; begins saturated so the first start passes
	always_ff @(posedge clock_i) begin
		if (!nrst_i) gap_q <= 10'h3FF;
		else if (conv_start_o) gap_q <= 10'h000;
		else if (gap_q != 10'h3FF) gap_q <= gap_q + 10'h001;
	end
	// Last started channel; seven makes the expected first start zero
	always_ff @(posedge clock_i) begin
		if (!nrst_i) last_q <= 3'h7;
		else if (conv_start_o) last_q <= conv_chan_o;
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	a_top_bit_zero: assert property (!channel_index_and_sample_high_o[7])
		else $error("upper byte top bit set");
	a_start_one_pulse: assert property (conv_start_o |=> !conv_start_o)
		else $error("start longer than one cycle");
	a_start_spacing: assert property (conv_start_o |-> gap_q >= CONV_CYCLES)
		else $error("starts too close");
	a_first_start: assert property ($rose(nrst_i) |-> ##[1:3] conv_start_o)
		else $error("no start after reset");
	a_chan_limit: assert property (conv_start_o |-> conv_chan_o <= chan_jumper_i)
		else $error("disabled channel converted");
	a_chan_order: assert property (conv_start_o |->
		conv_chan_o == ((last_q == chan_jumper_i) ? 3'h0 : last_q + 3'h1))
		else $error("conversion order broken");
	a_index_limit: assert property (idx <= chan_jumper_i)
		else $error("disabled channel presented");
	a_scan_paced: assert property (($changed(sample_low_byte_o) ||
		$changed(channel_index_and_sample_high_o)) |-> age_q inside {[1:6]})
		else $error("bytes changed without a scan");
	a_index_step: assert property (($changed(sample_low_byte_o) ||
		$changed(channel_index_and_sample_high_o)) |-> idx == 3'h0 || idx == $past(idx) + 3'h1)
		else $error("index did not step");
endmodule // mas_scanner_chk
bind mas_scanner mas_scanner_chk #(.FIFO_DEPTH(FIFO_DEPTH)) mas_scanner_chk_i (
	.clock_i(clock_i), .nrst_i(nrst_i), .chan_jumper_i(chan_jumper_i),
	.host_scan_i(host_scan_i), .conv_done_i(conv_done_i), .conv_code_i(conv_code_i),
	.conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
	.sample_low_byte_o(sample_low_byte_o),
	.channel_index_and_sample_high_o(channel_index_and_sample_high_o)
);
`default_nettype wire

// ---- tb/mas_conv_model.sv ----
// Behavioural converter standing behind the scanner
`timescale 1ns/10ps
`default_nettype none
module mas_conv_model
	import mas_pkg::*;
(
	input wire logic clock_i,
	input wire logic slow_i,
	input wire logic conv_start_i,
	input wire logic [CHAN_W-1:0] conv_chan_i,
	output logic conv_done_o,
	output logic [CODE_W-1:0] conv_code_o
);
	int wait_q = -10;
	logic [CODE_W-1:0] code_q = 12'h000;
	// Range ends on the first and last channel, a mixed pattern elsewhere
	function automatic logic [CODE_W-1:0] code_of(input logic [CHAN_W-1:0] c);
		return (c == 3'h0) ? 12'h000 : (c == 3'h7) ? 12'hFFF : {c, c, c, 3'h5};
	endfunction
	// Slow mode answers after the minimum wait so the done edge sets the pace
	always @(posedge clock_i) begin
		if (conv_start_i) begin
			wait_q <= slow_i ? 900 : 5;
			code_q <= code_of(conv_chan_i);
		end else if (wait_q > -4) begin
			wait_q <= wait_q - 1;
		end
	end
	// Done holds four cycles; the bus shows the inverse outside it
	assign conv_done_o = (wait_q <= 0) && (wait_q > -4);
	assign conv_code_o = conv_done_o ? code_q : ~code_q;
endmodule // mas_conv_model
`default_nettype wire

// ---- tb/mas_scanner_tb.sv ----
// Self-checking bench for the channel scanner
`timescale 1ns/10ps
`default_nettype none
module mas_scanner_tb;
	import mas_pkg::*;
	logic clock_i, nrst_i, host_scan_i, slow, conv_start, conv_done;
	logic [CHAN_W-1:0] jumper, conv_chan;
	logic [CODE_W-1:0] conv_code, code;
	logic [BYTE_W-1:0] low_b, up_b;
	int bad_count, tests_run;
	logic [CHAN_W-1:0] jmp_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
	mas_scanner #(.FIFO_DEPTH(FIFO_DEPTH)) mas_scanner_i (
		.clock_i(clock_i), .nrst_i(nrst_i), .chan_jumper_i(jumper),
		.host_scan_i(host_scan_i), .conv_done_i(conv_done), .conv_code_i(conv_code),
		.conv_start_o(conv_start), .conv_chan_o(conv_chan),
		.sample_low_byte_o(low_b), .channel_index_and_sample_high_o(up_b)
	);
	mas_conv_model mas_conv_model_i (
		.clock_i(clock_i), .slow_i(slow), .conv_start_i(conv_start),
		.conv_chan_i(conv_chan), .conv_done_o(conv_done), .conv_code_o(conv_code)
	);
	// 20 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Straps change only under reset, as on a real board
	task automatic reset_to(input logic [CHAN_W-1:0] j, input logic s);
		@(posedge clock_i);
		nrst_i <= 1'b0;
		jumper <= j;
		slow <= s;
		repeat (10) @(posedge clock_i);
		nrst_i <= 1'b1;
	endtask
	// One host scan; bytes are read 1 ns after the last edge to let it settle
	task automatic scan(input int gap);
		repeat (gap) @(posedge clock_i);
		host_scan_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		host_scan_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		#1;
	endtask
	task automatic expect_idx(input logic [CHAN_W-1:0] i);
		code = mas_conv_model_i.code_of(i);
		check(up_b, {1'b0, i, code[11:8]});
		check(low_b, code[7:0]);
	endtask
	task automatic results();
		$display("Checks run %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Hang guard well beyond the expected run
	initial begin
		repeat (60000) @(posedge clock_i);
		bad_count++;
		results();
	end
	initial begin
		nrst_i = 1'b0;
		host_scan_i = 1'b0;
		jumper = 3'h7;
		slow = 1'b0;
		bad_count = 0;
		tests_run = 0;
		// Scan before any result exists: bytes keep their reset value
		reset_to(3'h7, 1'b0);
		scan(2);
		check(up_b, UP_RST);
		check(low_b, LOW_RST);
		// Each strap setting in jmp_tab: fill the buffer, read each enabled channel once back to back, then wrap
		foreach (jmp_tab[t]) begin
			reset_to(jmp_tab[t], jmp_tab[t][0]);
			repeat (7700) @(posedge clock_i);
			for (int k = 0; k <= jmp_tab[t] + 1; k++) begin
				scan(k < 8 ? 2 : 960);
				expect_idx(k > jmp_tab[t] ? 3'h0 : k[2:0]);
			end
		end
		results();
	end
endmodule // mas_scanner_tb
`default_nettype wire
